// ===== logic/dbg_pkg.sv
`default_nettype none
package dbg_pkg;

  localparam int W = 16;
  localparam int AW = 10;

  // Procedure codes
  localparam logic [W-1:0] PROC_BLOCK_COPY = 16'h001B;
  localparam logic [W-1:0] PROC_BLOCK_FILL = 16'h001C;
  localparam logic [W-1:0] PROC_BLOCK_READ = 16'h001D;
  localparam logic [W-1:0] PROC_BLOCK_WRITE = 16'h0020;
  localparam logic [W-1:0] PROC_CYCLE_DELAY = 16'h0038;
  localparam logic [W-1:0] PROC_REG_PEEK = 16'h003D;
  localparam logic [W-1:0] PROC_REG_POKE = 16'h003E;
  localparam logic [W-1:0] PROC_PATTERN = 16'h0046;
  localparam logic [W-1:0] PROC_BIT_COMPARE = 16'h0047;

  // Register-write actions
  localparam logic [W-1:0] ACT_REPLACE = 16'h0000;
  localparam logic [W-1:0] ACT_SET = 16'h0001;
  localparam logic [W-1:0] ACT_CLEAR = 16'h0002;

  // Error word returned with err set
  localparam logic [W-1:0] BAD_ARGUMENT_ERROR = 16'h0001;

  // Pattern test: in_seq[i] = k*(3+2i), out_seq[i] = k*(11-2i)
  localparam logic [W-1:0] PAT_WORDS = 16'h0005;
  localparam logic [W-1:0] PAT_IN_BASE = 16'h0003;
  localparam logic [W-1:0] PAT_OUT_BASE = 16'h000B;
  localparam logic [W-1:0] PAT_STEP = 16'h0002;

  // Parameter slots and counts
  localparam int MAX_PARAMS = 5;
  localparam logic [2:0] POKE_ARM = 3'h0;

  typedef enum {ST_CODE, ST_PARAM, ST_RUN} dbg_state_e;

  typedef struct packed {
    logic err;
    logic [W-1:0] data;
  } dbg_res_s;

  function automatic logic [2:0] dbg_nparams(input logic [W-1:0] code);
    case (code)
      PROC_BLOCK_COPY: dbg_nparams = 3'h5;
      PROC_BLOCK_FILL: dbg_nparams = 3'h4;
      PROC_BLOCK_READ, PROC_BLOCK_WRITE, PROC_BIT_COMPARE, PROC_REG_POKE: dbg_nparams = 3'h3;
      PROC_PATTERN: dbg_nparams = 3'h5;
      PROC_CYCLE_DELAY, PROC_REG_PEEK: dbg_nparams = 3'h1;
      default: dbg_nparams = 3'h0;
    endcase
  endfunction : dbg_nparams

endpackage : dbg_pkg
`default_nettype wire

// ===== logic/dbg_command_unit.sv
`timescale 1ns/100ps
`default_nettype none
module dbg_command_unit #(
  parameter int BUF_SPAN = 64,
  parameter int NREG = 8,
  parameter logic [NREG-1:0] WO_MASK = '0,
  parameter logic [NREG*dbg_pkg::W-1:0] CTRL_RST = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Procedure word stream from the host
  input wire logic in_valid,
  input wire logic [dbg_pkg::W-1:0] in_word,
  output logic in_ready_ff,
  // Return values
  output logic res_valid_ff,
  output dbg_pkg::dbg_res_s res_ff,
  output logic done_ff,
  // Control registers and interrupt block
  output logic [NREG*dbg_pkg::W-1:0] ctrl_ff,
  output logic irq_block_ff
);

  localparam int W = dbg_pkg::W;
  localparam int AW = dbg_pkg::AW;

  logic [W-1:0] ram [0:(1<<AW)-1];
  logic [W-1:0] p_ff [0:dbg_pkg::MAX_PARAMS-1];
  dbg_pkg::dbg_state_e state_ff, nxt_state;
  logic [W-1:0] code_ff;
  logic [2:0] pidx_ff;
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic [W-1:0] errs_ff, nxt_errs;
  logic [W-1:0] k_ff;

  wire take = in_valid && in_ready_ff;
  wire [2:0] np_in = dbg_pkg::dbg_nparams(in_word);
  wire [2:0] np_cur = dbg_pkg::dbg_nparams(code_ff);

  // Buffer addresses: selector picks a fixed-size window of data RAM for block procedures; bit compare uses absolute addresses
  wire [AW-1:0] base01 = AW'(p_ff[0] * W'(BUF_SPAN) + p_ff[1]);
  wire [AW-1:0] copy_src = AW'(p_ff[0] * W'(BUF_SPAN) + p_ff[2] + cnt_ff);
  wire [AW-1:0] copy_dst = AW'(p_ff[1] * W'(BUF_SPAN) + p_ff[3] + cnt_ff);
  wire [AW-1:0] blk_addr = AW'(base01 + AW'(cnt_ff));
  wire [AW-1:0] info_addr = AW'(p_ff[0] + cnt_ff);
  wire [AW-1:0] cmi_addr = AW'(p_ff[1] + cnt_ff);

  // Soft decision sign bit against hard bit in LSB
  wire bit_mismatch = ram[cmi_addr][W-1] != ram[info_addr][0];

  // Pattern test terms for word cnt_ff
  wire [2:0] pat_i = cnt_ff[2:0];
  wire [W-1:0] pat_expect = W'(k_ff * W'(dbg_pkg::PAT_IN_BASE + dbg_pkg::PAT_STEP * cnt_ff));
  wire [W-1:0] pat_out = W'(k_ff * W'(dbg_pkg::PAT_OUT_BASE - dbg_pkg::PAT_STEP * cnt_ff));
  wire [W-1:0] pat_param = (pat_i < 3'(dbg_pkg::MAX_PARAMS)) ? p_ff[pat_i] : '0;
  wire [W-1:0] pat_err_max = W'(dbg_pkg::PAT_WORDS - 16'h0001);

  // Register index checks
  wire [W-1:0] reg_idx = p_ff[0];
  wire idx_ok = reg_idx < W'(NREG);
  wire [$clog2(NREG)-1:0] ridx = idx_ok ? reg_idx[$clog2(NREG)-1:0] : '0;
  wire [W-1:0] reg_cur = ctrl_ff[ridx*W +: W];
  wire reg_wo = WO_MASK[ridx];
  wire peek_ok = idx_ok && !reg_wo;
  wire [W-1:0] poke_val = p_ff[1];
  wire [W-1:0] poke_act = p_ff[2];
  wire poke_ok = idx_ok && (poke_act == dbg_pkg::ACT_REPLACE ||
                 (!reg_wo && (poke_act == dbg_pkg::ACT_SET || poke_act == dbg_pkg::ACT_CLEAR)));
  wire [W-1:0] poke_new = (poke_act == dbg_pkg::ACT_SET) ? (reg_cur | poke_val) :
                          (poke_act == dbg_pkg::ACT_CLEAR) ? (reg_cur & ~poke_val) : poke_val;

  // Per-procedure run control
  logic run_fin, run_emit, run_err, ram_we, poke_we, block_irq, cnt_step;
  logic [W-1:0] run_data, ram_wdata;
  logic [AW-1:0] ram_waddr;

  always_comb
  begin
    run_fin = 1'b0;
    run_emit = 1'b0;
    run_err = 1'b0;
    run_data = '0;
    ram_we = 1'b0;
    ram_waddr = '0;
    ram_wdata = '0;
    poke_we = 1'b0;
    block_irq = 1'b0;
    cnt_step = 1'b1;
    nxt_errs = errs_ff;
    case (code_ff)
      dbg_pkg::PROC_BLOCK_COPY:
      begin
        run_fin = cnt_ff == p_ff[4];
        ram_we = !run_fin;
        ram_waddr = copy_dst;
        ram_wdata = ram[copy_src];
      end
      dbg_pkg::PROC_BLOCK_FILL:
      begin
        run_fin = cnt_ff == p_ff[3];
        ram_we = !run_fin;
        ram_waddr = blk_addr;
        ram_wdata = p_ff[2];
      end
      dbg_pkg::PROC_BLOCK_READ:
      begin
        run_fin = cnt_ff == p_ff[2];
        run_emit = !run_fin;
        run_data = ram[blk_addr];
      end
      dbg_pkg::PROC_BLOCK_WRITE:
      begin
        run_fin = cnt_ff == p_ff[2];
        cnt_step = take;
        ram_we = take;
        ram_waddr = blk_addr;
        ram_wdata = in_word;
      end
      dbg_pkg::PROC_BIT_COMPARE:
      begin
        run_fin = cnt_ff == p_ff[2];
        run_emit = run_fin;
        run_data = errs_ff;
        if (!run_fin && bit_mismatch)
        begin
          nxt_errs = W'(errs_ff + 1'b1);
        end
      end
      dbg_pkg::PROC_PATTERN:
      begin
        run_fin = cnt_ff == dbg_pkg::PAT_WORDS;
        run_emit = 1'b1;
        run_data = run_fin ? errs_ff : pat_out;
        // Reported range stops one below the word count, so five misses saturate at four
        if (!run_fin && pat_param != pat_expect && errs_ff < pat_err_max)
        begin
          nxt_errs = W'(errs_ff + 1'b1);
        end
      end
      dbg_pkg::PROC_REG_PEEK:
      begin
        run_fin = 1'b1;
        run_emit = 1'b1;
        run_err = !peek_ok;
        run_data = peek_ok ? reg_cur : dbg_pkg::BAD_ARGUMENT_ERROR;
      end
      dbg_pkg::PROC_REG_POKE:
      begin
        // Interrupts are held off for the update cycle only, registered from the arm cycle
        block_irq = 1'b1;
        run_fin = cnt_ff != W'(dbg_pkg::POKE_ARM);
        poke_we = run_fin && poke_ok;
        run_emit = run_fin && !poke_ok;
        run_err = 1'b1;
        run_data = dbg_pkg::BAD_ARGUMENT_ERROR;
      end
      dbg_pkg::PROC_CYCLE_DELAY:
      begin
        run_fin = cnt_ff == p_ff[0];
      end
      default:
      begin
        run_fin = 1'b1;
        run_emit = 1'b1;
        run_err = 1'b1;
        run_data = dbg_pkg::BAD_ARGUMENT_ERROR;
      end
    endcase
  end

  // Sequencing: code, parameters, run; next call only after finish
  logic nxt_ready;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      dbg_pkg::ST_CODE:
      begin
        nxt_cnt = '0;
        if (take)
        begin
          nxt_state = (np_in == 3'h0) ? dbg_pkg::ST_RUN : dbg_pkg::ST_PARAM;
        end
      end
      dbg_pkg::ST_PARAM:
      begin
        if (take && pidx_ff == np_cur - 3'h1)
        begin
          nxt_state = dbg_pkg::ST_RUN;
        end
      end
      dbg_pkg::ST_RUN:
      begin
        if (run_fin)
        begin
          nxt_state = dbg_pkg::ST_CODE;
        end
        else if (cnt_step)
        begin
          nxt_cnt = W'(cnt_ff + 1'b1);
        end
      end
      default:
      begin
        nxt_state = dbg_pkg::ST_CODE;
      end
    endcase
  end

  // Data words are accepted mid-run only while the write count is short
  assign nxt_ready = (nxt_state != dbg_pkg::ST_RUN) ||
                     (state_ff == dbg_pkg::ST_RUN && code_ff == dbg_pkg::PROC_BLOCK_WRITE && nxt_cnt < p_ff[2]);

  wire in_run = state_ff == dbg_pkg::ST_RUN;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_ff <= dbg_pkg::ST_CODE;
      code_ff <= '0;
      pidx_ff <= '0;
      cnt_ff <= '0;
      errs_ff <= '0;
      k_ff <= '0;
      in_ready_ff <= 1'b0;
      res_valid_ff <= 1'b0;
      res_ff <= '0;
      done_ff <= 1'b0;
      irq_block_ff <= 1'b0;
      ctrl_ff <= CTRL_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      in_ready_ff <= nxt_ready;
      res_valid_ff <= in_run && run_emit;
      res_ff <= '{err: run_err, data: run_data};
      done_ff <= in_run && run_fin;
      irq_block_ff <= in_run && block_irq && !run_fin;
      errs_ff <= in_run ? nxt_errs : '0;
      if (state_ff == dbg_pkg::ST_CODE && take)
      begin
        code_ff <= in_word;
        pidx_ff <= '0;
      end
      else if (state_ff == dbg_pkg::ST_PARAM && take)
      begin
        p_ff[pidx_ff] <= in_word;
        pidx_ff <= pidx_ff + 3'h1;
      end
      if (in_run && run_fin && code_ff == dbg_pkg::PROC_PATTERN)
      begin
        k_ff <= W'(k_ff + 1'b1);
      end
      if (in_run && poke_we)
      begin
        ctrl_ff[ridx*W +: W] <= poke_new;
      end
    end
  end

  // Data RAM holds no reset; contents are undefined until written
  always_ff @(posedge core_clk)
  begin
    if (in_run && ram_we)
    begin
      ram[ram_waddr] <= ram_wdata;
    end
  end

endmodule : dbg_command_unit
`default_nettype wire

// ===== verif/dbg_host.sv
`timescale 1ns/100ps
`default_nettype none
module dbg_host (
  // Clock
  input wire logic core_clk,
  // Word stream into the device
  input wire logic in_ready_ff,
  output logic in_valid,
  output logic [15:0] in_word
);
  logic [15:0] q[$];
  logic taken;
  task automatic send(input logic [15:0] w);
    q.push_back(w);
  endtask : send
  initial
  begin
    in_valid = 1'b0;
    in_word = 16'h0000;
    taken = 1'b0;
  end
  // Ready is registered, so the level seen mid-cycle is the one sampled at the edge
  always @(negedge core_clk) taken = in_valid && in_ready_ff;
  always @(posedge core_clk)
  begin
    #1;
    if (taken)
      void'(q.pop_front());
    in_valid = (q.size() != 0);
    // An idle bus keeps toggling so a stale word can never pass for a fresh one
    in_word = in_valid ? q[0] : ~in_word;
  end
endmodule : dbg_host
`default_nettype wire

// ===== verif/dbg_command_unit_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dbg_command_unit_asserts #(
  parameter int NREG = 8,
  parameter logic [NREG*dbg_pkg::W-1:0] CTRL_RST = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Device outputs
  input wire logic in_ready_ff,
  input wire logic res_valid_ff,
  input wire dbg_pkg::dbg_res_s res_ff,
  input wire logic done_ff,
  input wire logic [NREG*dbg_pkg::W-1:0] ctrl_ff,
  input wire logic irq_block_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !in_ready_ff && !done_ff && ctrl_ff == CTRL_RST)
    else $error("outputs not idle after reset");
  a_done_ready: assert property (done_ff |-> in_ready_ff)
    else $error("done without ready");
  a_res_busy: assert property (res_valid_ff && !done_ff |-> !in_ready_ff)
    else $error("new call accepted while results pending");
  a_err_code: assert property (res_valid_ff && res_ff.err |-> res_ff.data == dbg_pkg::BAD_ARGUMENT_ERROR)
    else $error("error word wrong");
  a_irq_short: assert property ($rose(irq_block_ff) |=> !irq_block_ff && done_ff)
    else $error("interrupt block not one cycle before done");
  a_irq_busy: assert property (irq_block_ff |-> !in_ready_ff && !done_ff)
    else $error("ready during register update");
  a_ctrl_guard: assert property (!$stable(ctrl_ff) |-> $past(irq_block_ff))
    else $error("register changed outside blocked update");
  a_done_pulse: assert property (done_ff |=> !done_ff)
    else $error("done longer than one cycle");
endmodule : dbg_command_unit_asserts
bind dbg_command_unit dbg_command_unit_asserts #(.NREG(NREG), .CTRL_RST(CTRL_RST)) u_asserts (
  .core_clk(core_clk), .rst(rst), .in_ready_ff(in_ready_ff), .res_valid_ff(res_valid_ff),
  .res_ff(res_ff), .done_ff(done_ff), .ctrl_ff(ctrl_ff), .irq_block_ff(irq_block_ff));
`default_nettype wire

// ===== verif/dbg_command_unit_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dbg_command_unit_bench;
  logic core_clk, rst, in_valid, in_ready_ff, res_valid_ff, done_ff, irq_block_ff;
  logic [15:0] in_word, a, b, r, m;
  logic [127:0] ctrl_ff;
  logic [15:0] d[$], p[$];
  dbg_pkg::dbg_res_s res_ff;
  dbg_pkg::dbg_res_s eq[$];
  int n_errors = 0, cmp_count = 0, seed = 32'hd00d, nk, t0, t20;
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  dbg_command_unit #(.WO_MASK(8'h80)) u_dut (.core_clk(core_clk), .rst(rst), .in_valid(in_valid), .in_word(in_word),
    .in_ready_ff(in_ready_ff), .res_valid_ff(res_valid_ff), .res_ff(res_ff), .done_ff(done_ff),
    .ctrl_ff(ctrl_ff), .irq_block_ff(irq_block_ff));
  dbg_host u_host (.core_clk(core_clk), .in_ready_ff(in_ready_ff), .in_valid(in_valid), .in_word(in_word));
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic ex(input logic e, input logic [15:0] v);
    eq.push_back('{e, v});
  endtask : ex
  task automatic call(input logic [15:0] w[$], output int n);
    n = 0;
    foreach (w[i]) u_host.send(w[i]);
    while (done_ff !== 1'b1)
    begin
      @(posedge core_clk);
      #2;
      n++;
      if (n > 3000)
      begin
        n_errors++;
        end_sim();
      end
    end
    @(posedge core_clk);
    #2;
  endtask : call
  always @(posedge core_clk)
  begin
    #2;
    if (res_valid_ff === 1'b1)
      check(res_ff, eq.size() ? eq.pop_front() : 'x);
  end
  initial
  begin
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    ex(1'b0, 16'h0000);
    call({16'h003D, 16'h0000}, nk);
    ex(1'b1, dbg_pkg::BAD_ARGUMENT_ERROR);
    call({16'h003D, 16'h0008}, nk);
    a = $random(seed);
    b = $random(seed);
    call({16'h003E, 16'h0002, a, 16'h0000}, nk);
    check(ctrl_ff[47:32], a);
    call({16'h003E, 16'h0002, b, 16'h0001}, nk);
    check(ctrl_ff[47:32], a | b);
    call({16'h003E, 16'h0002, a, 16'h0002}, nk);
    check(ctrl_ff[47:32], b & ~a);
    ex(1'b0, b & ~a);
    call({16'h003D, 16'h0002}, nk);
    ex(1'b1, dbg_pkg::BAD_ARGUMENT_ERROR);
    call({16'h003E, 16'h0009, a, 16'h0000}, nk);
    ex(1'b1, dbg_pkg::BAD_ARGUMENT_ERROR);
    call({16'h003E, 16'h0002, a, 16'h0003}, nk);
    check(ctrl_ff[47:32], b & ~a);
    ex(1'b1, dbg_pkg::BAD_ARGUMENT_ERROR);
    call({16'h003E, 16'h0007, b, 16'h0001}, nk);
    call({16'h003E, 16'h0007, a, 16'h0000}, nk);
    check(ctrl_ff[127:112], a);
    ex(1'b1, dbg_pkg::BAD_ARGUMENT_ERROR);
    call({16'h003D, 16'h0007}, nk);
    ex(1'b1, dbg_pkg::BAD_ARGUMENT_ERROR);
    call({16'h00FF}, nk);
    d = {};
    repeat (17) d.push_back($random(seed));
    call({16'h0020, 16'h0001, 16'h0003, 16'h0011, d}, nk);
    foreach (d[i]) ex(1'b0, d[i]);
    call({16'h001D, 16'h0001, 16'h0003, 16'h0011}, nk);
    r = $random(seed);
    call({16'h001C, 16'h0002, 16'h0000, r, 16'h0004}, nk);
    call({16'h001B, 16'h0002, 16'h0003, 16'h0000, 16'h0005, 16'h0004}, nk);
    repeat (4) ex(1'b0, r);
    call({16'h001D, 16'h0003, 16'h0005, 16'h0004}, nk);
    m = 16'h0000;
    foreach (d[i]) if (i < 4 && d[i][0] != d[i+4][15]) m++;
    call({16'h0020, 16'h0004, 16'h0000, 16'h0004, d[0], d[1], d[2], d[3]}, nk);
    call({16'h0020, 16'h0005, 16'h0000, 16'h0004, d[4], d[5], d[6], d[7]}, nk);
    ex(1'b0, m);
    call({16'h0047, 16'h0100, 16'h0140, 16'h0004}, nk);
    for (int k = 0; k < 4; k++)
    begin
      p = {16'h0046};
      for (int i = 0; i < 5; i++) p.push_back(16'(k * (3 + 2 * i)) ^ 16'((k == 2 && i > 2) || k == 3));
      for (int i = 0; i < 5; i++) ex(1'b0, 16'(k * (11 - 2 * i)));
      ex(1'b0, (k == 2) ? 16'h0002 : (k == 3) ? 16'h0004 : 16'h0000);
      call(p, nk);
    end
    // Reset between calls: the pattern multiplier must restart from zero
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    p = {16'h0046, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (6) ex(1'b0, 16'h0000);
    call(p, nk);
    call({16'h0038, 16'h0000}, t0);
    call({16'h0038, 16'h0014}, t20);
    check(17'(t20 - t0), 17'h00014);
    check(17'(eq.size()), 17'h00000);
    end_sim();
  end
endmodule : dbg_command_unit_bench
`default_nettype wire
